// File: rtl/opc_pkg.sv
// constants and types for the operation condition word
`default_nettype none
package opc_pkg;
  localparam int CH_N = 2;
  localparam int GRP_N = 6;
  localparam int WORD_W = 16;
  // subordinate group indices
  localparam int GRP_CAL = 0;
  localparam int GRP_MEAS = 1;
  localparam int GRP_TRIG = 2;
  localparam int GRP_SENSE = 3;
  localparam int GRP_LOWER = 4;
  localparam int GRP_UPPER = 5;
  // bit position of each group summary in the condition word
  localparam int GRP_BIT [GRP_N] = '{0, 4, 5, 10, 11, 12};
  localparam logic [WORD_W-1:0] WORD_USED_MASK = 16'h1c31;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  typedef logic [CH_N-1:0] opc_ch_t;
  localparam opc_ch_t CH_NONE = 2'h0;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_ZERO = 3'b010,
    CAL_RUN = 3'b100
  } opc_cal_e;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_WAIT = 3'b010,
    MS_MEAS = 3'b100
  } opc_meas_e;
endpackage : opc_pkg
`default_nettype wire

// File: rtl/opc_sub_if.sv
// set/clear carrier between the core and one subordinate condition register
`timescale 1ns/10ps
`default_nettype none
interface opc_sub_if;
  import opc_pkg::*;
  opc_ch_t set_v;
  opc_ch_t clr_v;
  opc_ch_t cond;
  logic summary;
  modport ctl (output set_v, output clr_v, input cond, input summary);
  modport sub (input set_v, input clr_v, output cond, output summary);
endinterface : opc_sub_if
`default_nettype wire

// File: rtl/opc_subreg.sv
// one subordinate condition register with its summary
`timescale 1ns/10ps
`default_nettype none
module opc_subreg
  import opc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  opc_sub_if.sub port
);
  opc_ch_t cond_reg;

  // set beats clear so an event landing on a clear is not lost
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cond_reg <= CH_NONE;
    end else begin
      cond_reg <= (cond_reg & ~port.clr_v) | port.set_v;
    end
  end

  assign port.cond = cond_reg;
  assign port.summary = |cond_reg; // RULE_01
endmodule : opc_subreg
`default_nettype wire

// File: rtl/opc_limit_eval.sv
// limit verdict of a completed measurement, per channel
`timescale 1ns/10ps
`default_nettype none
module opc_limit_eval
  import opc_pkg::*;
(
  input wire opc_ch_t meas_done,
  input wire opc_ch_t test_en,
  input wire opc_ch_t chan_fail,
  input wire opc_ch_t win_fail,
  output opc_ch_t fail_set,
  output opc_ch_t fail_clr
);
  opc_ch_t failed;

  // a failure only counts while the test is enabled
  assign failed = test_en & (chan_fail | win_fail);
  assign fail_set = meas_done & failed; // RULE_09 RULE_11
  assign fail_clr = meas_done & ~failed; // RULE_10 RULE_12
endmodule : opc_limit_eval
`default_nettype wire

// File: rtl/opc_core.sv
// operation condition word: sequencer tracking and summary assembly
// Overview of operation
// (RULE_01) bits 0, 4, 5 summarise the calib_in_progress, measure_in_progress, trigger-wait registers
// (RULE_02) bit 0 sets when a single auto zero or single auto cal starts
// (RULE_03) calibrate-all sets bit 0 when its zeroing phase starts
// (RULE_04) bit 0 clears when the zero or calibration that set it ends
// (RULE_05) bit 4 stays high while a measurement runs
// (RULE_06) bit 4 clears when the measurement finishes
// (RULE_07) bit 5 sets entering trigger wait, clears entering idle
// (RULE_08) bit 10 is high only while sensor configuration memory is read
// (RULE_09) completed measurement with channel or window lower failure sets bit 11
// (RULE_10) completed measurement clears bit 11 if lower test off or passed
// (RULE_11) completed measurement with channel or window upper failure sets bit 12
// (RULE_12) completed measurement clears bit 12 if upper test off or passed
// (RULE_13) unused bits 1-3, 6-9, 13-15 always read zero
`timescale 1ns/10ps
`default_nettype none
module opc_core
  import opc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire opc_ch_t single_auto_zero_cmd,
  input wire opc_ch_t single_auto_cal_cmd,
  input wire opc_ch_t cal_all_go,
  input wire opc_ch_t cal_phase_end,
  input wire opc_ch_t cal_abort,
  input wire opc_ch_t trig_arm,
  input wire opc_ch_t trig_fire,
  input wire opc_ch_t trig_cont,
  input wire opc_ch_t trig_abort,
  input wire opc_ch_t meas_end,
  input wire opc_ch_t sensor_mem_rd,
  input wire opc_ch_t lower_test_en,
  input wire opc_ch_t lower_chan_fail,
  input wire opc_ch_t lower_win_fail,
  input wire opc_ch_t upper_test_en,
  input wire opc_ch_t upper_chan_fail,
  input wire opc_ch_t upper_win_fail,
  output logic [WORD_W-1:0] op_cond_word,
  output logic [GRP_N*CH_N-1:0] op_sub_cond,
  output opc_ch_t calib_in_progress,
  output opc_ch_t measure_in_progress
);
  opc_cal_e cal_st_reg [CH_N];
  opc_cal_e cal_st_next [CH_N];
  opc_ch_t all_seq_reg;
  opc_ch_t all_seq_next;
  opc_meas_e ms_st_reg [CH_N];
  opc_meas_e ms_st_next [CH_N];
  opc_ch_t cal_set;
  opc_ch_t cal_clr;
  opc_ch_t meas_set;
  opc_ch_t meas_clr;
  opc_ch_t trig_set;
  opc_ch_t trig_clr;
  opc_ch_t meas_done;
  opc_ch_t lower_set;
  opc_ch_t lower_clr;
  opc_ch_t upper_set;
  opc_ch_t upper_clr;
  logic [GRP_N-1:0] summ;
  logic [GRP_N*CH_N-1:0] cond_all;
  logic [WORD_W-1:0] op_cond_word_reg;
  logic [WORD_W-1:0] op_cond_word_next;
  logic [GRP_N*CH_N-1:0] op_sub_cond_reg;
  opc_ch_t calib_reg;
  opc_ch_t measure_reg;

  function automatic logic [WORD_W-1:0] place_summary(input logic [GRP_N-1:0] s);
    logic [WORD_W-1:0] w;
    w = WORD_RST;
    for (int g = 0; g < GRP_N; g++) begin
      w[GRP_BIT[g]] = s[g];
    end
    return w & WORD_USED_MASK;
  endfunction : place_summary

  // any state but idle means a zero or calibration owns the channel
  function automatic logic cal_busy(input opc_cal_e st);
    return st != CAL_IDLE;
  endfunction : cal_busy

  function automatic logic ms_enters(input opc_meas_e cur, input opc_meas_e nxt,
    input opc_meas_e tgt);
    return (cur != tgt) && (nxt == tgt);
  endfunction : ms_enters

  function automatic logic ms_leaves(input opc_meas_e cur, input opc_meas_e nxt,
    input opc_meas_e tgt);
    return (cur == tgt) && (nxt != tgt);
  endfunction : ms_leaves

  opc_sub_if sub_if [GRP_N] ();

  for (genvar g = 0; g < GRP_N; g++) begin : g_sub
    opc_subreg u_sub (
      .mclk(mclk),
      .rst_b(rst_b),
      .port(sub_if[g])
    );
    assign summ[g] = sub_if[g].summary;
    assign cond_all[g*CH_N +: CH_N] = sub_if[g].cond;
  end

  // calibration sequence per channel; a start while busy is ignored
  always_comb begin
    all_seq_next = all_seq_reg;
    for (int c = 0; c < CH_N; c++) begin
      cal_st_next[c] = cal_st_reg[c];
      case (cal_st_reg[c])
        CAL_IDLE: begin
          if (single_auto_zero_cmd[c] || cal_all_go[c]) begin
            cal_st_next[c] = CAL_ZERO; // RULE_02 RULE_03
            all_seq_next[c] = cal_all_go[c];
          end else if (single_auto_cal_cmd[c]) begin
            cal_st_next[c] = CAL_RUN; // RULE_02
            all_seq_next[c] = 1'b0;
          end
        end
        CAL_ZERO: begin
          if (cal_abort[c]) begin
            cal_st_next[c] = CAL_IDLE;
          end else if (cal_phase_end[c]) begin
            // calibrate-all keeps bit 0 up across the hand-off to calibration
            cal_st_next[c] = all_seq_reg[c] ? CAL_RUN : CAL_IDLE;
          end
        end
        CAL_RUN: begin
          if (cal_abort[c] || cal_phase_end[c]) begin
            cal_st_next[c] = CAL_IDLE;
          end
        end
        default: begin
          cal_st_next[c] = CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CH_N; c++) begin
        cal_st_reg[c] <= CAL_IDLE;
      end
    end else begin
      for (int c = 0; c < CH_N; c++) begin
        cal_st_reg[c] <= cal_st_next[c];
      end
    end
  end

  // remembers that the running zero belongs to a calibrate-all
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      all_seq_reg <= CH_NONE;
    end else begin
      all_seq_reg <= all_seq_next;
    end
  end

  // trigger and measurement sequence per channel
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      ms_st_next[c] = ms_st_reg[c];
      case (ms_st_reg[c])
        MS_IDLE: begin
          if (trig_arm[c]) begin
            ms_st_next[c] = MS_WAIT;
          end
        end
        MS_WAIT: begin
          if (trig_abort[c]) begin
            ms_st_next[c] = MS_IDLE;
          end else if (trig_fire[c]) begin
            ms_st_next[c] = MS_MEAS;
          end
        end
        MS_MEAS: begin
          if (trig_abort[c]) begin
            ms_st_next[c] = MS_IDLE;
          end else if (meas_end[c]) begin
            ms_st_next[c] = trig_cont[c] ? MS_WAIT : MS_IDLE;
          end
        end
        default: begin
          ms_st_next[c] = MS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CH_N; c++) begin
        ms_st_reg[c] <= MS_IDLE;
      end
    end else begin
      for (int c = 0; c < CH_N; c++) begin
        ms_st_reg[c] <= ms_st_next[c];
      end
    end
  end

  // set and clear strobes come from state entries and exits
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      cal_set[c] = !cal_busy(cal_st_reg[c]) && cal_busy(cal_st_next[c]); // RULE_02 RULE_03
      cal_clr[c] = cal_busy(cal_st_reg[c]) && !cal_busy(cal_st_next[c]); // RULE_04
    end
  end

  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      meas_set[c] = ms_enters(ms_st_reg[c], ms_st_next[c], MS_MEAS); // RULE_05
      meas_clr[c] = ms_leaves(ms_st_reg[c], ms_st_next[c], MS_MEAS); // RULE_06
      trig_set[c] = ms_enters(ms_st_reg[c], ms_st_next[c], MS_WAIT); // RULE_07
      trig_clr[c] = ms_enters(ms_st_reg[c], ms_st_next[c], MS_IDLE); // RULE_07
    end
  end

  // an aborted measurement is not a completed one and leaves limits alone
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      meas_done[c] = (ms_st_reg[c] == MS_MEAS) && meas_end[c] && !trig_abort[c];
    end
  end

  opc_limit_eval u_lower (
    .meas_done(meas_done),
    .test_en(lower_test_en),
    .chan_fail(lower_chan_fail),
    .win_fail(lower_win_fail),
    .fail_set(lower_set),
    .fail_clr(lower_clr)
  );

  opc_limit_eval u_upper (
    .meas_done(meas_done),
    .test_en(upper_test_en),
    .chan_fail(upper_chan_fail),
    .win_fail(upper_win_fail),
    .fail_set(upper_set),
    .fail_clr(upper_clr)
  );

  assign sub_if[GRP_CAL].set_v = cal_set;
  assign sub_if[GRP_CAL].clr_v = cal_clr;
  assign sub_if[GRP_MEAS].set_v = meas_set;
  assign sub_if[GRP_MEAS].clr_v = meas_clr;
  assign sub_if[GRP_TRIG].set_v = trig_set;
  assign sub_if[GRP_TRIG].clr_v = trig_clr;

  // bit 10 tracks the read level; every cycle without a read clears it
  assign sub_if[GRP_SENSE].set_v = sensor_mem_rd; // RULE_08
  assign sub_if[GRP_SENSE].clr_v = ~sensor_mem_rd; // RULE_08

  // limit bits move only on a completed measurement, never on an abort
  assign sub_if[GRP_LOWER].set_v = lower_set; // RULE_09
  assign sub_if[GRP_LOWER].clr_v = lower_clr; // RULE_10
  assign sub_if[GRP_UPPER].set_v = upper_set; // RULE_11
  assign sub_if[GRP_UPPER].clr_v = upper_clr; // RULE_12

  // the word lags the subordinate registers by one cycle so every output is a flop
  assign op_cond_word_next = place_summary(summ); // RULE_01 RULE_13

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_cond_word_reg <= WORD_RST;
    end else begin
      op_cond_word_reg <= op_cond_word_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_sub_cond_reg <= '0;
    end else begin
      op_sub_cond_reg <= cond_all;
    end
  end

  // in-progress copies share the word's lag, so one read sees one picture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      calib_reg <= CH_NONE;
    end else begin
      calib_reg <= sub_if[GRP_CAL].cond;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      measure_reg <= CH_NONE;
    end else begin
      measure_reg <= sub_if[GRP_MEAS].cond;
    end
  end

  assign op_cond_word = op_cond_word_reg;
  assign op_sub_cond = op_sub_cond_reg;
  assign calib_in_progress = calib_reg;
  assign measure_in_progress = measure_reg;
endmodule : opc_core
`default_nettype wire

// File: dv/opc_core_assertions.sv
// concurrent checks on the operation condition word
`timescale 1ns/10ps
`default_nettype none
module opc_core_assertions
  import opc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire opc_ch_t single_auto_zero_cmd,
  input wire opc_ch_t single_auto_cal_cmd,
  input wire opc_ch_t cal_all_go,
  input wire opc_ch_t cal_phase_end,
  input wire opc_ch_t cal_abort,
  input wire opc_ch_t trig_arm,
  input wire opc_ch_t trig_fire,
  input wire opc_ch_t trig_abort,
  input wire opc_ch_t meas_end,
  input wire opc_ch_t sensor_mem_rd,
  input wire logic [WORD_W-1:0] op_cond_word,
  input wire logic [GRP_N*CH_N-1:0] op_sub_cond,
  input wire opc_ch_t calib_in_progress
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  opc_ch_t go;
  opc_ch_t stp;
  assign go = single_auto_zero_cmd | single_auto_cal_cmd | cal_all_go;
  assign stp = cal_phase_end | cal_abort;
  a_unused_zero: assert property ((op_cond_word & ~WORD_USED_MASK) == 16'h0000)
    else $error("unused condition bit set");
  a_summary_or: assert property (op_cond_word[0] == |op_sub_cond[1:0]
    && op_cond_word[4] == |op_sub_cond[3:2] && op_cond_word[5] == |op_sub_cond[5:4])
    else $error("summary bit differs from its subordinate register");
  a_cal_start: assert property (go[0] && !calib_in_progress[0] && !stp[0] ##1 !stp[0]
    |-> ##1 op_cond_word[0]) else $error("calib_in_progress bit not set on start");
  a_cal_clear: assert property ($fell(op_cond_word[0]) |-> $past(stp, 2) != 2'h0)
    else $error("calib_in_progress bit cleared without an end");
  a_meas_set: assert property ($rose(op_cond_word[4]) |-> $past(trig_fire, 2) != 2'h0)
    else $error("measure_in_progress bit set without a trigger");
  a_meas_clear: assert property ($fell(op_cond_word[4])
    |-> $past(meas_end | trig_abort, 2) != 2'h0) else $error("measure_in_progress bit cleared early");
  a_trig_set: assert property ($rose(op_cond_word[5]) |-> $past(trig_arm, 2) != 2'h0)
    else $error("trigger wait bit set without arming");
  a_trig_clear: assert property ($fell(op_cond_word[5])
    |-> $past(meas_end | trig_abort, 2) != 2'h0) else $error("trigger wait bit cleared early");
  a_sense_lag: assert property ($past(rst_b, 2)
    |-> op_cond_word[10] == |$past(sensor_mem_rd, 2)) else $error("sense bit wrong");
  a_lower_upd: assert property ($changed(op_cond_word[11])
    |-> $past(meas_end, 2) != 2'h0) else $error("lower fail bit moved without a measurement");
  a_upper_upd: assert property ($changed(op_cond_word[12])
    |-> $past(meas_end, 2) != 2'h0) else $error("upper fail bit moved without a measurement");
  c_cal: cover property ($rose(op_cond_word[0]));
  c_upper: cover property ($rose(op_cond_word[12]));
  c_sense: cover property ($rose(op_cond_word[10]));
endmodule : opc_core_assertions
bind opc_core opc_core_assertions opc_core_assertions_i (.mclk, .rst_b, .single_auto_zero_cmd,
  .single_auto_cal_cmd, .cal_all_go, .cal_phase_end, .cal_abort, .trig_arm, .trig_fire,
  .trig_abort, .meas_end, .sensor_mem_rd, .op_cond_word, .op_sub_cond, .calib_in_progress);
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the operation condition word
`timescale 1ns/10ps
`default_nettype none
module tb
  import opc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  opc_ch_t s [9];
  opc_ch_t cont, mem, len, lcf, lwf, uen, ucf, uwf, cip, mip;
  logic [WORD_W-1:0] word;
  logic [GRP_N*CH_N-1:0] sub;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  opc_core opc_core_i (.mclk(mclk), .rst_b(rst_b), .single_auto_zero_cmd(s[0]),
    .single_auto_cal_cmd(s[1]), .cal_all_go(s[2]), .cal_phase_end(s[3]), .cal_abort(s[4]),
    .trig_arm(s[5]), .trig_fire(s[6]), .trig_cont(cont), .trig_abort(s[7]), .meas_end(s[8]),
    .sensor_mem_rd(mem), .lower_test_en(len), .lower_chan_fail(lcf), .lower_win_fail(lwf),
    .upper_test_en(uen), .upper_chan_fail(ucf), .upper_win_fail(uwf), .op_cond_word(word),
    .op_sub_cond(sub), .calib_in_progress(cip), .measure_in_progress(mip));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // ceiling well above the fewer than 100 cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  task step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  // one-cycle strobe; word answers after the second edge
  task pls(int i, opc_ch_t ch);
    s[i] = ch;
    step(1);
    s[i] = CH_NONE;
    step(1);
  endtask : pls
  // arm, trigger and finish one measurement on the given channels
  task run_meas(opc_ch_t ch);
    pls(5, ch);
    pls(6, ch);
    pls(8, ch);
  endtask : run_meas
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task t_cal;
    pls(0, 2'h1);
    chk("zero", word, 16'h0001);
    chk("cip", {14'h0, cip}, 16'h0001);
    pls(3, 2'h1);
    chk("zero end", word, 16'h0000);
    pls(1, 2'h2);
    chk("cal", word, 16'h0001);
    pls(4, 2'h2);
    chk("cal abort", word, 16'h0000);
    pls(0, 2'h2);
    chk("zero ch1", word, 16'h0001);
    pls(4, 2'h2);
    chk("zero abort", word, 16'h0000);
    pls(2, 2'h1);
    chk("all", word, 16'h0001);
    pls(3, 2'h1);
    chk("all mid", word, 16'h0001);
    pls(3, 2'h1);
    chk("all end", word, 16'h0000);
    // a start while busy is ignored, so one end finishes it
    pls(0, 2'h1);
    pls(1, 2'h1);
    pls(3, 2'h1);
    chk("busy", word, 16'h0000);
    $display("t_cal done");
  endtask : t_cal
  task t_meas;
    pls(5, 2'h1);
    chk("arm", word, 16'h0020);
    pls(6, 2'h1);
    chk("fire", word, 16'h0030);
    chk("mip", {14'h0, mip}, 16'h0001);
    cont = 2'h1;
    len = 2'h1;
    lcf = 2'h1;
    uen = 2'h1;
    pls(8, 2'h1);
    chk("end cont", word, 16'h0820);
    cont = 2'h0;
    pls(6, 2'h1);
    chk("fire2", word, 16'h0830);
    len = 2'h0;
    uwf = 2'h1;
    pls(8, 2'h1);
    chk("end idle", word, 16'h1000);
    uen = 2'h0;
    len = 2'h3;
    lcf = 2'h0;
    lwf = 2'h2;
    run_meas(2'h2);
    chk("ch1", word, 16'h1800);
    chk("ch1 sub", {4'h0, sub}, 16'h0600);
    run_meas(2'h1);
    chk("up off", word, 16'h0800);
    pls(5, 2'h1);
    pls(6, 2'h1);
    pls(7, 2'h1);
    chk("abort", word, 16'h0800);
    pls(5, 2'h1);
    pls(7, 2'h1);
    chk("wait abort", word, 16'h0800);
    len = 2'h0;
    run_meas(2'h2);
    chk("low off", word, 16'h0000);
    uen = 2'h1;
    uwf = 2'h0;
    ucf = 2'h1;
    run_meas(2'h1);
    chk("up chan", word, 16'h1000);
    ucf = 2'h0;
    run_meas(2'h1);
    chk("up pass", word, 16'h0000);
    $display("t_meas done");
  endtask : t_meas
  task t_sense;
    mem = 2'h2;
    step(1);
    chk("sense lag", word, 16'h0000);
    step(1);
    chk("sense", word, 16'h0400);
    mem = 2'h0;
    step(2);
    chk("sense off", word, 16'h0000);
    $display("t_sense done");
  endtask : t_sense
  task t_rst;
    pls(0, 2'h1);
    rst_b = 1'b0;
    step(1);
    chk("rst", word, 16'h0000);
    rst_b = 1'b1;
    step(1);
    chk("rst rel", {4'h0, sub}, 16'h0000);
    pls(5, 2'h2);
    chk("rst arm", word, 16'h0020);
    $display("t_rst done");
  endtask : t_rst
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    foreach (s[i]) s[i] = CH_NONE;
    {cont, mem, len, lcf, lwf, uen, ucf, uwf} = 16'h0000;
    repeat (3) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk("reset", word, WORD_RST);
    t_cal();
    t_meas();
    t_sense();
    t_rst();
    stop_test();
  end
endmodule : tb
`default_nettype wire
